// file: design/ccr_pkg.sv
// charger control register bank: offsets, reset values, field layout and types
// Operation
// [R1] Mode register bit 7: 0 charging (reset), 1 reverse discharging.
// [R2] Host keeps reserved bits at power-on values; device stores them as written.
// [R3] Mode bit 4 scales input regulation: 0 gives 100x, 1 gives 40x.
// [R4] Mode bits 3-2 switching rate: 150, 300 (reset), reserved, 450 kHz.
// [R5] Mode bits 1-0 dead time: 20 (reset), 40, 60, 80 ns.
// [R6] Options bit 7 picks bus-side (0) or battery-side (1) charge current reference.
// [R7] Options bit 6: 0 keeps trickle phase, 1 skips it.
// [R8] Options bit 5: 0 enables automatic termination, 1 disables it.
// [R9] Options bit 4, discharging only: internal setting (0) or external divider (1).
// [R10] Options bit 3 trickle threshold: 70% (reset) or 60% of battery voltage.
// [R11] Options bit 2, discharging only: 0 keeps overvoltage guard, 1 turns off.
// [R12] Ramp bits 5-4 soft start: 0.0625, 0.125, 0.25, 0.5 mV/us.
// [R13] Host sets ramp register bit 3 after every power-up; it resets to 0.
// [R14] Ramp bit 2: 0 gate pin drives series switch, 1 enables frequency spreading.
// [R15] Ramp bits 1-0 discharge slew: 1, 2 (reset), 4, 8 mV/us.
// [R16] Each register reads back its last write and returns to reset value.
package ccr_pkg;

	localparam int unsigned CCR_NREG = 3;

	// register offsets on the serial register port
	localparam logic [7:0] CCR_ADDR_MODE = 8'h09;
	localparam logic [7:0] CCR_ADDR_OPTS = 8'h0A;
	localparam logic [7:0] CCR_ADDR_RAMP = 8'h0B;
	localparam logic [CCR_NREG-1:0][7:0] CCR_REG_ADDR = {CCR_ADDR_RAMP, CCR_ADDR_OPTS, CCR_ADDR_MODE};

	// power-on values
	localparam logic [7:0] CCR_RST_MODE = 8'h04;
	localparam logic [7:0] CCR_RST_OPTS = 8'h01;
	localparam logic [7:0] CCR_RST_RAMP = 8'h01;
	localparam logic [CCR_NREG-1:0][7:0] CCR_REG_RST = {CCR_RST_RAMP, CCR_RST_OPTS, CCR_RST_MODE};
	localparam logic [7:0] CCR_RDATA_UNMAPPED = 8'h00;

	// mode register fields
	localparam int unsigned CCR_MODE_DISCHARGE = 7;
	localparam int unsigned CCR_MODE_SCALE     = 4;
	localparam int unsigned CCR_MODE_RATE_LO   = 2;
	localparam int unsigned CCR_MODE_DT_LO     = 0;
	// options register fields
	localparam int unsigned CCR_OPTS_IREF      = 7;
	localparam int unsigned CCR_OPTS_TRICKLE   = 6;
	localparam int unsigned CCR_OPTS_TERM      = 5;
	localparam int unsigned CCR_OPTS_FBSRC     = 4;
	localparam int unsigned CCR_OPTS_TRTHR     = 3;
	localparam int unsigned CCR_OPTS_OVP       = 2;
	// ramp register fields
	localparam int unsigned CCR_RAMP_SS_LO     = 4;
	localparam int unsigned CCR_RAMP_FACTORY   = 3;
	localparam int unsigned CCR_RAMP_SPREAD    = 2;
	localparam int unsigned CCR_RAMP_SLEW_LO   = 0;

	// switching rate codes and values
	localparam logic [1:0] CCR_RATE_150 = 2'h0;
	localparam logic [1:0] CCR_RATE_300 = 2'h1;
	localparam logic [1:0] CCR_RATE_RSV = 2'h2;
	localparam logic [1:0] CCR_RATE_450 = 2'h3;
	localparam logic [8:0] CCR_KHZ_150  = 9'h096;
	localparam logic [8:0] CCR_KHZ_300  = 9'h12C;
	localparam logic [8:0] CCR_KHZ_450  = 9'h1C2;
	localparam logic [8:0] CCR_KHZ_NONE = 9'h000;
	// dead time in ns: 20 plus 20 per code step
	localparam logic [6:0] CCR_DT_BASE_NS = 7'h14;
	// input regulation scale factors
	localparam logic [6:0] CCR_SCALE_HI = 7'h64;
	localparam logic [6:0] CCR_SCALE_LO = 7'h28;
	// trickle threshold in percent
	localparam logic [6:0] CCR_TRTHR_HI = 7'h46;
	localparam logic [6:0] CCR_TRTHR_LO = 7'h3C;
	// soft start in 0.0625 mV/us steps and slew in mV/us, both doubling per code
	localparam logic [3:0] CCR_RATE_UNIT = 4'h1;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ccr_req_t;

	// raw field view of the three registers
	typedef struct packed {
		logic       discharge_mode_select;
		logic       input_regulation_scale;
		logic [1:0] switch_rate_select;
		logic [1:0] deadtime_select;
		logic       charge_current_reference_select;
		logic       trickle_phase_off;
		logic       auto_terminate_off;
		logic       output_voltage_source_select;
		logic       trickle_threshold_low;
		logic       overvoltage_guard_off;
		logic [1:0] startup_ramp_select;
		logic       factory_set;
		logic       frequency_spread_on;
		logic [1:0] slew_select;
	} ccr_cfg_t;

	// decoded settings handed to the power stage
	typedef struct packed {
		logic [8:0] switch_khz;
		logic       switch_code_invalid;
		logic [6:0] deadtime_ns;
		logic [6:0] input_scale_x;
		logic       battery_current_ref;
		logic       trickle_enabled;
		logic       auto_terminate_enabled;
		logic       external_feedback;
		logic [6:0] trickle_threshold_pct;
		logic       overvoltage_guard_active;
		logic [3:0] startup_ramp_units;
		logic       gate_pin_spread;
		logic [3:0] slew_mv_per_us;
	} ccr_stage_t;

endpackage

// file: design/ccr_byte_reg.sv
// one byte-wide control register with a power-on value
`timescale 1ns/1ps
module ccr_byte_reg #(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	// write port
	input  wire logic       we_i,
	input  wire logic [7:0] wdata_i,
	// stored value
	output logic      [7:0] q_o
);

	logic [7:0] val_d;
	logic [7:0] val_q;

	always_comb begin
		val_d = val_q;
		if (we_i) begin
			val_d = wdata_i; // R16
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			val_q <= RST_VAL; // R16
		end else begin
			val_q <= val_d;
		end
	end

	assign q_o = val_q;

endmodule

// file: design/ccr_regbank.sv
// control register bank: storage, readback and decode into power stage settings
`timescale 1ns/1ps
module ccr_regbank (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	// register port from the serial host link
	input  wire ccr_pkg::ccr_req_t  reg_req_i,
	output logic              [7:0] reg_rdata_o,
	output logic                    reg_rvalid_o,
	output logic                    reg_miss_o,
	// configuration to the power stage
	output ccr_pkg::ccr_cfg_t       cfg_o,
	output ccr_pkg::ccr_stage_t     stage_o,
	output logic                    setup_pending_o
);
	import ccr_pkg::*;

	logic [CCR_NREG-1:0][7:0] reg_q;
	logic [CCR_NREG-1:0]      hit;
	logic                     any_hit;

	// one register per entry, each with its own power-on value
	generate
		for (genvar i = 0; i < CCR_NREG; i++) begin : g_reg
			assign hit[i] = (reg_req_i.addr == CCR_REG_ADDR[i]);
			ccr_byte_reg #(
				.RST_VAL (CCR_REG_RST[i])
			) u_reg (
				.clk_i     (clk_i),
				.sys_rst_i (sys_rst_i),
				.we_i      (reg_req_i.wr && hit[i]),
				.wdata_i   (reg_req_i.wdata),
				.q_o       (reg_q[i])
			);
		end
	endgenerate

	assign any_hit = |hit;

	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic       rvalid_d;
	logic       rvalid_q;
	logic       miss_d;
	logic       miss_q;

	// a read in the same cycle as a write to that register sees the old value
	always_comb begin
		rdata_d  = CCR_RDATA_UNMAPPED;
		rvalid_d = reg_req_i.rd;
		miss_d   = (reg_req_i.rd || reg_req_i.wr) && !any_hit;
		for (int k = 0; k < CCR_NREG; k++) begin
			if (reg_req_i.rd && hit[k]) begin
				rdata_d = reg_q[k]; // R16
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q  <= CCR_RDATA_UNMAPPED;
			rvalid_q <= 1'b0;
			miss_q   <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
			miss_q   <= miss_d;
		end
	end

	assign reg_rdata_o  = rdata_q;
	assign reg_rvalid_o = rvalid_q;
	assign reg_miss_o   = miss_q;

	// reserved bits are stored and read back as written but drive nothing
	logic [7:0] mode_r;
	logic [7:0] opts_r;
	logic [7:0] ramp_r;
	assign mode_r = reg_q[0]; // R2
	assign opts_r = reg_q[1];
	assign ramp_r = reg_q[2];

	// field view comes straight from the register flops
	always_comb begin
		cfg_o.discharge_mode_select           = mode_r[CCR_MODE_DISCHARGE]; // R1
		cfg_o.input_regulation_scale          = mode_r[CCR_MODE_SCALE];
		cfg_o.switch_rate_select              = mode_r[CCR_MODE_RATE_LO +: 2];
		cfg_o.deadtime_select                 = mode_r[CCR_MODE_DT_LO +: 2];
		cfg_o.charge_current_reference_select = opts_r[CCR_OPTS_IREF];
		cfg_o.trickle_phase_off               = opts_r[CCR_OPTS_TRICKLE];
		cfg_o.auto_terminate_off              = opts_r[CCR_OPTS_TERM];
		cfg_o.output_voltage_source_select    = opts_r[CCR_OPTS_FBSRC];
		cfg_o.trickle_threshold_low           = opts_r[CCR_OPTS_TRTHR];
		cfg_o.overvoltage_guard_off           = opts_r[CCR_OPTS_OVP];
		cfg_o.startup_ramp_select             = ramp_r[CCR_RAMP_SS_LO +: 2];
		cfg_o.factory_set                     = ramp_r[CCR_RAMP_FACTORY];
		cfg_o.frequency_spread_on             = ramp_r[CCR_RAMP_SPREAD];
		cfg_o.slew_select                     = ramp_r[CCR_RAMP_SLEW_LO +: 2];
	end

	ccr_stage_t stage_d;
	ccr_stage_t stage_q;
	logic       pending_d;
	logic       pending_q;

	always_comb begin
		stage_d = stage_q;
		case (cfg_o.switch_rate_select) // R4
			CCR_RATE_150: stage_d.switch_khz = CCR_KHZ_150;
			CCR_RATE_300: stage_d.switch_khz = CCR_KHZ_300;
			CCR_RATE_450: stage_d.switch_khz = CCR_KHZ_450;
			default:      stage_d.switch_khz = CCR_KHZ_NONE;
		endcase
		// the reserved rate code is flagged instead of guessed at
		stage_d.switch_code_invalid = (cfg_o.switch_rate_select == CCR_RATE_RSV); // R4
		stage_d.deadtime_ns = CCR_DT_BASE_NS + 7'(CCR_DT_BASE_NS * 7'(cfg_o.deadtime_select)); // R5
		// 40x keeps resolution when the regulation target is under 10 V; the host picks it
		stage_d.input_scale_x = cfg_o.input_regulation_scale ? CCR_SCALE_LO : CCR_SCALE_HI; // R3
		stage_d.battery_current_ref    = cfg_o.charge_current_reference_select; // R6
		stage_d.trickle_enabled        = !cfg_o.trickle_phase_off; // R7
		stage_d.auto_terminate_enabled = !cfg_o.auto_terminate_off; // R8
		// feedback source and guard disable only bite while discharging
		stage_d.external_feedback = cfg_o.discharge_mode_select
			&& cfg_o.output_voltage_source_select; // R9
		stage_d.trickle_threshold_pct = cfg_o.trickle_threshold_low ? CCR_TRTHR_LO : CCR_TRTHR_HI; // R10
		stage_d.overvoltage_guard_active = !(cfg_o.discharge_mode_select
			&& cfg_o.overvoltage_guard_off); // R11
		stage_d.startup_ramp_units = CCR_RATE_UNIT << cfg_o.startup_ramp_select; // R12
		stage_d.gate_pin_spread    = cfg_o.frequency_spread_on; // R14
		stage_d.slew_mv_per_us     = CCR_RATE_UNIT << cfg_o.slew_select; // R15
		pending_d = !cfg_o.factory_set; // R13
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stage_q.switch_khz               <= CCR_KHZ_300;
			stage_q.switch_code_invalid      <= 1'b0;
			stage_q.deadtime_ns              <= CCR_DT_BASE_NS;
			stage_q.input_scale_x            <= CCR_SCALE_HI;
			stage_q.battery_current_ref      <= 1'b0;
			stage_q.trickle_enabled          <= 1'b1;
			stage_q.auto_terminate_enabled   <= 1'b1;
			stage_q.external_feedback        <= 1'b0;
			stage_q.trickle_threshold_pct    <= CCR_TRTHR_HI;
			stage_q.overvoltage_guard_active <= 1'b1;
			stage_q.startup_ramp_units       <= CCR_RATE_UNIT;
			stage_q.gate_pin_spread          <= 1'b0;
			stage_q.slew_mv_per_us           <= 4'h2;
			pending_q                        <= 1'b1;
		end else begin
			stage_q   <= stage_d;
			pending_q <= pending_d;
		end
	end

	assign stage_o         = stage_q;
	assign setup_pending_o = pending_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_wr_mode;
		reg_req_i.wr && reg_req_i.addr == CCR_ADDR_MODE;
	endsequence
	sequence s_rd_mode;
		reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == CCR_ADDR_MODE;
	endsequence
	sequence s_wr_opts;
		reg_req_i.wr && reg_req_i.addr == CCR_ADDR_OPTS;
	endsequence
	sequence s_rd_opts;
		reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == CCR_ADDR_OPTS;
	endsequence
	sequence s_wr_ramp;
		reg_req_i.wr && reg_req_i.addr == CCR_ADDR_RAMP;
	endsequence
	sequence s_rd_ramp;
		reg_req_i.rd && !reg_req_i.wr && reg_req_i.addr == CCR_ADDR_RAMP;
	endsequence

	AST_READBACK: // R16
	assert property (s_wr_mode ##1 s_rd_mode |=> reg_rvalid_o && reg_rdata_o == $past(reg_req_i.wdata, 2))
		else $error("mode register did not read back last write");
	AST_DIRECTION: // R1
	assert property (s_wr_mode |=> cfg_o.discharge_mode_select == $past(reg_req_i.wdata[7]))
		else $error("direction bit not taken from write");
	AST_SCALE: // R3
	assert property (cfg_o.input_regulation_scale |=> stage_o.input_scale_x == 7'h28)
		else $error("40x scale not selected");
	AST_RATE: // R4
	assert property (cfg_o.switch_rate_select == 2'h3 |=> stage_o.switch_khz == 9'h1C2
		&& !stage_o.switch_code_invalid)
		else $error("450 kHz code decoded wrongly");
	AST_DEADTIME: // R5
	assert property (cfg_o.deadtime_select == 2'h3 |=> stage_o.deadtime_ns == 7'h50)
		else $error("80 ns dead time decoded wrongly");
	AST_FEEDBACK: // R9
	assert property (!cfg_o.discharge_mode_select |=> !stage_o.external_feedback)
		else $error("external feedback used while charging");
	AST_GUARD: // R11
	assert property (cfg_o.discharge_mode_select && cfg_o.overvoltage_guard_off
		|=> !stage_o.overvoltage_guard_active)
		else $error("overvoltage guard not released while discharging");
	AST_GUARD_CHG: // R11
	assert property (!cfg_o.discharge_mode_select |=> stage_o.overvoltage_guard_active)
		else $error("overvoltage guard off while charging");
	AST_TRICKLE: // R7
	assert property (cfg_o.trickle_phase_off |=> !stage_o.trickle_enabled)
		else $error("trickle phase not skipped");
	AST_THRESHOLD: // R10
	assert property (cfg_o.trickle_threshold_low |=> stage_o.trickle_threshold_pct == 7'h3C)
		else $error("60 percent threshold not selected");
	AST_RAMP: // R12
	assert property (cfg_o.startup_ramp_select == 2'h3 |=> stage_o.startup_ramp_units == 4'h8)
		else $error("fastest soft start decoded wrongly");
	AST_SLEW: // R15
	assert property (cfg_o.slew_select == 2'h0 |=> stage_o.slew_mv_per_us == 4'h1)
		else $error("slowest slew decoded wrongly");
	AST_SPREAD: // R14
	assert property ($rose(cfg_o.frequency_spread_on) |=> stage_o.gate_pin_spread)
		else $error("gate pin role did not follow spread bit");
	AST_TERM: // R8
	assert property (cfg_o.auto_terminate_off |=> !stage_o.auto_terminate_enabled)
		else $error("auto termination still enabled");
	AST_IREF: // R6
	assert property (cfg_o.charge_current_reference_select |=> stage_o.battery_current_ref)
		else $error("battery side reference not selected");

	// register port behaviour: readback, old data on a shared cycle, refused writes
	AST_READBACK_OPTS: // R16
	assert property (s_wr_opts ##1 s_rd_opts |=> reg_rvalid_o && reg_rdata_o == $past(reg_req_i.wdata, 2))
		else $error("options register did not read back last write");
	AST_READBACK_RAMP: // R16
	assert property (s_wr_ramp ##1 s_rd_ramp |=> reg_rvalid_o && reg_rdata_o == $past(reg_req_i.wdata, 2))
		else $error("ramp register did not read back last write");
	AST_RD_OLD: // R16
	assert property (reg_req_i.rd && reg_req_i.wr && hit[0] |=> reg_rdata_o == $past(mode_r))
		else $error("shared read and write did not return old contents");
	AST_HOLD: // R16
	assert property (!reg_req_i.wr |=> $stable(reg_q))
		else $error("register changed without a write");
	AST_MISS_WR: // R16
	assert property (reg_req_i.wr && !any_hit |=> $stable(reg_q))
		else $error("unmapped write changed a register");
	AST_RVALID: // R16
	assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read not answered");
	AST_RVALID_IDLE: // R16
	assert property (!reg_req_i.rd |=> !reg_rvalid_o)
		else $error("read valid without a read");
	AST_MISS_SET: // R16
	assert property ((reg_req_i.rd || reg_req_i.wr) && !any_hit |=> reg_miss_o)
		else $error("unmapped access not flagged");
	AST_MISS_CLR: // R16
	assert property (any_hit || !(reg_req_i.rd || reg_req_i.wr) |=> !reg_miss_o)
		else $error("miss flagged for a mapped or idle cycle");
	AST_MISS_RDATA: // R16
	assert property (reg_req_i.rd && !any_hit |=> reg_rdata_o == CCR_RDATA_UNMAPPED)
		else $error("unmapped read returned data");

	// setup status and decode of the remaining codes
	AST_PENDING_CLR: // R13
	assert property (cfg_o.factory_set |=> !setup_pending_o)
		else $error("setup still pending after factory bit set");
	AST_PENDING_SET: // R13
	assert property (!cfg_o.factory_set |=> setup_pending_o)
		else $error("setup pending not shown while factory bit clear");
	AST_RATE_RSV: // R4
	assert property (cfg_o.switch_rate_select == CCR_RATE_RSV |=> stage_o.switch_code_invalid
		&& stage_o.switch_khz == CCR_KHZ_NONE)
		else $error("reserved rate code not flagged");
	AST_RATE_150: // R4
	assert property (cfg_o.switch_rate_select == CCR_RATE_150 |=> stage_o.switch_khz == CCR_KHZ_150)
		else $error("150 kHz code decoded wrongly");
	AST_RATE_300: // R4
	assert property (cfg_o.switch_rate_select == CCR_RATE_300 |=> stage_o.switch_khz == CCR_KHZ_300)
		else $error("300 kHz code decoded wrongly");
	AST_DEADTIME_MIN: // R5
	assert property (cfg_o.deadtime_select == 2'h0 |=> stage_o.deadtime_ns == 7'h14)
		else $error("20 ns dead time decoded wrongly");
	AST_SCALE_HI: // R3
	assert property (!cfg_o.input_regulation_scale |=> stage_o.input_scale_x == 7'h64)
		else $error("100x scale not selected");
	AST_THRESHOLD_HI: // R10
	assert property (!cfg_o.trickle_threshold_low |=> stage_o.trickle_threshold_pct == 7'h46)
		else $error("70 percent threshold not selected");
	AST_FEEDBACK_EXT: // R9
	assert property (cfg_o.discharge_mode_select && cfg_o.output_voltage_source_select
		|=> stage_o.external_feedback)
		else $error("external feedback not used while discharging");
	AST_SPREAD_OFF: // R14
	assert property (!cfg_o.frequency_spread_on |=> !stage_o.gate_pin_spread)
		else $error("gate pin spreading while spread bit clear");
	AST_IREF_BUS: // R6
	assert property (!cfg_o.charge_current_reference_select |=> !stage_o.battery_current_ref)
		else $error("bus side reference not selected");
	AST_TRICKLE_ON: // R7
	assert property (!cfg_o.trickle_phase_off |=> stage_o.trickle_enabled)
		else $error("trickle phase skipped while enabled");
	AST_TERM_ON: // R8
	assert property (!cfg_o.auto_terminate_off |=> stage_o.auto_terminate_enabled)
		else $error("auto termination disabled while enabled");
	AST_RAMP_MIN: // R12
	assert property (cfg_o.startup_ramp_select == 2'h0 |=> stage_o.startup_ramp_units == 4'h1)
		else $error("slowest soft start decoded wrongly");
	AST_SLEW_MAX: // R15
	assert property (cfg_o.slew_select == 2'h3 |=> stage_o.slew_mv_per_us == 4'h8)
		else $error("fastest slew decoded wrongly");

endmodule

// file: dv/ccr_host_model.sv
// host stand-in that drives the register port of the control register bank
`timescale 1ns/1ps
module ccr_host_model (
	// clock
	input  wire logic         clk_i,
	// register port
	output ccr_pkg::ccr_req_t reg_req_o,
	input  wire logic   [7:0] reg_rdata_i,
	input  wire logic         reg_rvalid_i,
	input  wire logic         reg_miss_i
);
	import ccr_pkg::*;

	initial reg_req_o = '0;

	// reserved bits are forced back to their power-on values before any write
	function automatic logic [7:0] keep(input logic [7:0] a, input logic [7:0] d);
		case (a)
			CCR_ADDR_MODE: return {d[7], 2'h0, d[4:0]};
			CCR_ADDR_OPTS: return {d[7:2], CCR_RST_OPTS[1:0]};
			CCR_ADDR_RAMP: return {2'h0, d[5:0]};
			default:       return d;
		endcase
	endfunction

	// caller stands one step after a rising edge; the request stays up for back-to-back use
	task automatic access(input logic [7:0] a, input logic w, input logic r, input logic [7:0] d,
		output logic [7:0] q, output logic v, output logic m);
		reg_req_o = '{addr: a, wr: w, rd: r, wdata: w ? keep(a, d) : d};
		@(posedge clk_i);
		#1;
		q = reg_rdata_i;
		v = reg_rvalid_i;
		m = reg_miss_i;
	endtask

	// released lines flip so a stale value can never look valid
	task automatic idle();
		reg_req_o = '{addr: ~reg_req_o.addr, wr: 1'b0, rd: 1'b0, wdata: ~reg_req_o.wdata};
		@(posedge clk_i);
		#1;
	endtask

	task automatic power_up(output logic [7:0] q, output logic v, output logic m);
		access(CCR_ADDR_RAMP, 1'b1, 1'b0, CCR_RST_RAMP | 8'h08, q, v, m);
	endtask
endmodule

// file: dv/tb_top.sv
// self-checking bench for the charger control register bank
`timescale 1ns/1ps
module tb_top;
	import ccr_pkg::*;

	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	ccr_req_t    reg_req;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	logic        reg_miss;
	ccr_cfg_t    cfg;
	ccr_stage_t  stage;
	logic        setup_pending;
	logic [7:0]  q;
	logic        v;
	logic        m;
	logic [7:0]  sh [4];
	int          bad_count = 0;
	int          comparisons = 0;
	logic [15:0] rows [11] = '{16'h0900, 16'h0915, 16'h090A, 16'h098F, 16'h0AFD, 16'h090D,
		16'h0B1D, 16'h0B20, 16'h0B3A, 16'h0B0B, 16'h0A01};

	always #2 clk_i = ~clk_i;

	ccr_host_model host_u (
		.clk_i        (clk_i),
		.reg_req_o    (reg_req),
		.reg_rdata_i  (reg_rdata),
		.reg_rvalid_i (reg_rvalid),
		.reg_miss_i   (reg_miss)
	);

	ccr_regbank dut_u (
		.clk_i           (clk_i),
		.sys_rst_i       (sys_rst_i),
		.reg_req_i       (reg_req),
		.reg_rdata_o     (reg_rdata),
		.reg_rvalid_o    (reg_rvalid),
		.reg_miss_o      (reg_miss),
		.cfg_o           (cfg),
		.stage_o         (stage),
		.setup_pending_o (setup_pending)
	);

	task automatic end_of_test();
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] s);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic chk_bit(input string n, input logic e, input logic s);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %b seen %b", n, e, s);
		end
	endtask

	task automatic chk_vec(input string n, input logic [63:0] e, input logic [63:0] s);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	function automatic ccr_stage_t exp_stage(input logic [7:0] md, input logic [7:0] o, input logic [7:0] r);
		ccr_stage_t s;
		s.switch_khz = md[3:2] == 2'h0 ? CCR_KHZ_150 : md[3:2] == 2'h1 ? CCR_KHZ_300 :
			md[3:2] == 2'h3 ? CCR_KHZ_450 : CCR_KHZ_NONE;
		s.switch_code_invalid = md[3:2] == 2'h2;
		s.deadtime_ns = 7'h14 + 7'h14 * {5'h00, md[1:0]};
		s.input_scale_x = md[4] ? 7'h28 : 7'h64;
		s.battery_current_ref = o[7];
		s.trickle_enabled = ~o[6];
		s.auto_terminate_enabled = ~o[5];
		s.external_feedback = md[7] & o[4];
		s.trickle_threshold_pct = o[3] ? 7'h3C : 7'h46;
		s.overvoltage_guard_active = ~(md[7] & o[2]);
		s.startup_ramp_units = 4'h1 << r[5:4];
		s.gate_pin_spread = r[2];
		s.slew_mv_per_us = 4'h1 << r[1:0];
		return s;
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.access(a, 1'b1, 1'b0, d, q, v, m);
		chk_bit("wr miss", 1'b0, m);
		chk_bit("wr rvalid", 1'b0, v);
		sh[a[1:0]] = d;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		host_u.access(a, 1'b0, 1'b1, 8'h00, q, v, m);
		chk_byte("rdata", e, q);
		chk_bit("rvalid", 1'b1, v);
		chk_bit("rd miss", 1'b0, m);
	endtask

	task automatic check_all();
		chk_vec("cfg", ccr_cfg_t'({sh[1][7], sh[1][4:0], sh[2][7:2], sh[3][5:0]}), cfg);
		chk_vec("stage", exp_stage(sh[1], sh[2], sh[3]), stage);
		chk_bit("pending", ~sh[3][3], setup_pending);
	endtask

	// the three reads give three edges, so the decoded settings have settled by the compare
	task automatic check_rst();
		sh[1] = CCR_RST_MODE;
		sh[2] = CCR_RST_OPTS;
		sh[3] = CCR_RST_RAMP;
		rd_chk(CCR_ADDR_MODE, 8'h04);
		rd_chk(CCR_ADDR_OPTS, 8'h01);
		rd_chk(CCR_ADDR_RAMP, 8'h01);
		check_all();
	endtask

	task automatic do_reset();
		host_u.idle();
		sys_rst_i = 1'b1;
		repeat (8) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask

	initial begin
		#20000;
		bad_count++;
		end_of_test();
	end

	initial begin
		do_reset();
		check_rst();
		host_u.power_up(q, v, m);
		sh[3] = 8'h09;
		rd_chk(CCR_ADDR_RAMP, 8'h09);
		chk_bit("pending", 1'b0, setup_pending);
		foreach (rows[i]) begin
			wr(rows[i][15:8], rows[i][7:0]);
			rd_chk(rows[i][15:8], rows[i][7:0]);
			check_all();
		end
		host_u.access(8'h20, 1'b0, 1'b1, 8'h00, q, v, m);
		chk_byte("miss rdata", 8'h00, q);
		chk_bit("miss flag", 1'b1, m);
		chk_bit("miss rvalid", 1'b1, v);
		host_u.access(8'h0C, 1'b1, 1'b0, 8'hFF, q, v, m);
		chk_bit("miss wr", 1'b1, m);
		chk_bit("miss wr rvalid", 1'b0, v);
		host_u.idle();
		check_all();
		// read and write in one cycle must hand back the old contents
		host_u.access(CCR_ADDR_MODE, 1'b1, 1'b1, 8'h8F, q, v, m);
		chk_byte("rd old", sh[1], q);
		sh[1] = 8'h8F;
		rd_chk(CCR_ADDR_MODE, 8'h8F);
		check_all();
		do_reset();
		check_rst();
		host_u.idle();
		end_of_test();
	end
endmodule
